// ===== logic/cbha_pkg.sv
/*
  Constants and carrier types for the CPU bus hold arbiter.
  Assumes a single 100 MHz clock domain with synchronous active-high reset.
*/
`default_nettype none

package cbha_pkg;

  // Synchroniser depth for every pin input
  localparam int unsigned SYNC_STAGES = 3;

  // Clock period in ns, kept for reference by any derived count
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Pin inputs as one bundle
  typedef struct packed {
    logic master_cycle_request;
    logic cpu_release_ack;
    logic narrow_dma_addr_enable_n;
    logic wide_dma_addr_enable_n;
    logic local_master_request_n;
  } cbha_pins_t;

  localparam int unsigned PINS_W = $bits(cbha_pins_t);

  // Idle level of each pin: requests off, active-low enables high
  localparam cbha_pins_t PINS_IDLE = '{
    master_cycle_request:     1'h0,
    cpu_release_ack:          1'h0,
    narrow_dma_addr_enable_n: 1'h1,
    wide_dma_addr_enable_n:   1'h1,
    local_master_request_n:   1'h1
  };

  // DMA cycle decode results
  typedef struct packed {
    logic narrow_cycle;
    logic wide_cycle;
    logic width_conflict;
    logic cycle_start;
  } cbha_dma_status_t;

  localparam cbha_dma_status_t DMA_STATUS_RESET = '{
    narrow_cycle:   1'h0,
    wide_cycle:     1'h0,
    width_conflict: 1'h0,
    cycle_start:    1'h0
  };

  // Output reset levels
  localparam logic RELEASE_REQ_RESET = 1'h0;
  localparam logic MASTER_ACK_RESET  = 1'h0;
  localparam logic LOCAL_GRANT_N_RESET = 1'h1;

  typedef enum logic {
    CBHA_OWN_DMA,
    CBHA_OWN_LOCAL
  } cbha_owner_t;

  typedef enum logic [2:0] {
    CBHA_IDLE,
    CBHA_HOLD_REQ,
    CBHA_GRANT,
    CBHA_DROP,
    CBHA_RELEASE
  } cbha_state_t;

endpackage

`default_nettype wire

// ===== logic/cbha_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes inputs are asynchronous to clock; output changes once stages two and three agree.
*/
`default_nettype none

module cbha_sync #(
  parameter int unsigned                   WIDTH     = 1,
  parameter logic [WIDTH-1:0]              RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] dout_ff;
  logic [WIDTH-1:0] differ;

  // Stage one feeds stage two only, keeping metastability away from any gate
  always_ff @(posedge clock) begin
    if (srst) begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
    end else if (clk_en) begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign differ = s2_ff ^ s3_ff;

  // A bit moves only where the two late stages agree
  always_ff @(posedge clock) begin
    if (srst) begin
      dout_ff <= RESET_VAL;
    end else if (clk_en) begin
      dout_ff <= (s2_ff & ~differ) | (dout_ff & differ);
    end
  end

  assign dout = dout_ff;

endmodule

`default_nettype wire

// ===== logic/cbha_arbiter.sv
/*
  CPU bus hold arbiter: takes DMA/master and local-master requests, obtains the
  CPU buses through the release handshake, grants them and decodes DMA width.
  Assumes all pin inputs are asynchronous and pass the three-stage synchroniser,
  and that the CPU floats its pins before acknowledging release.
*/
`default_nettype none

// Summary of operation
// - Drive release request to take CPU buses
// - Grant only after CPU release acknowledge seen
// - Drive master-cycle acknowledge high when the DMA side is granted
// - Narrow enable low marks 8-bit DMA cycle
// - Wide enable low marks 16-bit DMA cycle
// - Local master request answered by low grant
module cbha_arbiter (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       clk_en,
  input  wire logic                       master_cycle_request,
  input  wire logic                       cpu_release_ack,
  input  wire logic                       narrow_dma_addr_enable_n,
  input  wire logic                       wide_dma_addr_enable_n,
  input  wire logic                       local_master_request_n,
  output logic                            cpu_release_request,
  output logic                            master_cycle_ack,
  output logic                            local_master_grant_n,
  output cbha_pkg::cbha_dma_status_t      dma_status
);

  cbha_pkg::cbha_pins_t   pins_raw;
  cbha_pkg::cbha_pins_t   pins;
  cbha_pkg::cbha_state_t  state_ff;
  cbha_pkg::cbha_state_t  nxt_state;
  cbha_pkg::cbha_owner_t  owner_ff;
  cbha_pkg::cbha_owner_t  nxt_owner;
  cbha_pkg::cbha_owner_t  last_owner_ff;
  logic                   release_req_ff;
  logic                   master_ack_ff;
  logic                   local_grant_n_ff;
  cbha_pkg::cbha_dma_status_t dma_status_ff;
  logic                   dma_req;
  logic                   local_req;
  logic                   owner_req;
  logic                   dma_granted;
  logic                   any_enable_ff;
  logic                   any_enable;

  assign pins_raw = '{
    master_cycle_request:     master_cycle_request,
    cpu_release_ack:          cpu_release_ack,
    narrow_dma_addr_enable_n: narrow_dma_addr_enable_n,
    wide_dma_addr_enable_n:   wide_dma_addr_enable_n,
    local_master_request_n:   local_master_request_n
  };

  cbha_sync #(
    .WIDTH     (cbha_pkg::PINS_W),
    .RESET_VAL (cbha_pkg::PINS_IDLE)
  ) u_sync (
    .clock  (clock),
    .srst   (srst),
    .clk_en (clk_en),
    .din    (pins_raw),
    .dout   (pins)
  );

  assign dma_req   = pins.master_cycle_request;
  assign local_req = ~pins.local_master_request_n;
  assign owner_req = (owner_ff == cbha_pkg::CBHA_OWN_DMA) ? dma_req : local_req;

  // Requester choice: alternate after a tenure so neither side starves
  always_comb begin
    nxt_owner = owner_ff;
    if (state_ff == cbha_pkg::CBHA_IDLE) begin
      if (dma_req && local_req) begin
        nxt_owner = (last_owner_ff == cbha_pkg::CBHA_OWN_DMA) ? cbha_pkg::CBHA_OWN_LOCAL
                                                              : cbha_pkg::CBHA_OWN_DMA;
      end else if (local_req) begin
        nxt_owner = cbha_pkg::CBHA_OWN_LOCAL;
      end else if (dma_req) begin
        nxt_owner = cbha_pkg::CBHA_OWN_DMA;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      cbha_pkg::CBHA_IDLE: begin
        // A stale acknowledge from the last tenure must clear before a new hold
        if ((dma_req || local_req) && !pins.cpu_release_ack) begin
          nxt_state = cbha_pkg::CBHA_HOLD_REQ;
        end
      end
      cbha_pkg::CBHA_HOLD_REQ: begin
        // The hold cannot be retracted mid-handshake; wait for the CPU either way
        if (pins.cpu_release_ack) begin
          nxt_state = owner_req ? cbha_pkg::CBHA_GRANT : cbha_pkg::CBHA_RELEASE;
        end
      end
      cbha_pkg::CBHA_GRANT: begin
        if (!owner_req) begin
          nxt_state = cbha_pkg::CBHA_DROP;
        end
      end
      cbha_pkg::CBHA_DROP: begin
        nxt_state = cbha_pkg::CBHA_RELEASE;
      end
      cbha_pkg::CBHA_RELEASE: begin
        if (!pins.cpu_release_ack) begin
          nxt_state = cbha_pkg::CBHA_IDLE;
        end
      end
      // Three spare codes exist; an upset lands back in idle
      default: begin
        nxt_state = cbha_pkg::CBHA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= cbha_pkg::CBHA_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      owner_ff      <= cbha_pkg::CBHA_OWN_DMA;
      last_owner_ff <= cbha_pkg::CBHA_OWN_LOCAL;
    end else if (clk_en) begin
      owner_ff <= nxt_owner;
      if (state_ff == cbha_pkg::CBHA_DROP) begin
        last_owner_ff <= owner_ff;
      end
    end
  end

  // Release request held from request through the drop cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      release_req_ff <= cbha_pkg::RELEASE_REQ_RESET;
    end else if (clk_en) begin
      release_req_ff <= (nxt_state == cbha_pkg::CBHA_HOLD_REQ) ||
                        (nxt_state == cbha_pkg::CBHA_GRANT) ||
                        (nxt_state == cbha_pkg::CBHA_DROP);
    end
  end

  // Acknowledge and grant only in the granted state, which follows the CPU's release
  always_ff @(posedge clock) begin
    if (srst) begin
      master_ack_ff <= cbha_pkg::MASTER_ACK_RESET;
    end else if (clk_en) begin
      master_ack_ff <= (nxt_state == cbha_pkg::CBHA_GRANT) &&
                       (nxt_owner == cbha_pkg::CBHA_OWN_DMA);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      local_grant_n_ff <= cbha_pkg::LOCAL_GRANT_N_RESET;
    end else if (clk_en) begin
      local_grant_n_ff <= !((nxt_state == cbha_pkg::CBHA_GRANT) &&
                            (nxt_owner == cbha_pkg::CBHA_OWN_LOCAL));
    end
  end

  // Width decode is meaningful only while the DMA side holds the buses
  assign dma_granted = (state_ff == cbha_pkg::CBHA_GRANT) && (owner_ff == cbha_pkg::CBHA_OWN_DMA);
  assign any_enable  = !pins.narrow_dma_addr_enable_n || !pins.wide_dma_addr_enable_n;

  always_ff @(posedge clock) begin
    if (srst) begin
      any_enable_ff <= 1'h0;
    end else if (clk_en) begin
      any_enable_ff <= dma_granted && any_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dma_status_ff <= cbha_pkg::DMA_STATUS_RESET;
    end else if (clk_en) begin
      dma_status_ff.narrow_cycle   <= dma_granted && !pins.narrow_dma_addr_enable_n;
      dma_status_ff.wide_cycle     <= dma_granted && !pins.wide_dma_addr_enable_n;
      dma_status_ff.width_conflict <= dma_granted && !pins.narrow_dma_addr_enable_n &&
                                      !pins.wide_dma_addr_enable_n;
      dma_status_ff.cycle_start    <= dma_granted && any_enable && !any_enable_ff;
    end
  end

  assign cpu_release_request  = release_req_ff;
  assign master_cycle_ack     = master_ack_ff;
  assign local_master_grant_n = local_grant_n_ff;
  assign dma_status           = dma_status_ff;

endmodule

`default_nettype wire

// ===== dv/cbha_sva.sv
/*
  Port checker for the CPU bus hold arbiter.
  Assumes one clock domain, synchronous active-high srst, three-stage pin synchronisers.
*/
`default_nettype none

module cbha_sva (
  input wire logic                       clock,
  input wire logic                       srst,
  input wire logic                       master_cycle_request,
  input wire logic                       cpu_release_ack,
  input wire logic                       narrow_dma_addr_enable_n,
  input wire logic                       wide_dma_addr_enable_n,
  input wire logic                       local_master_request_n,
  input wire logic                       cpu_release_request,
  input wire logic                       master_cycle_ack,
  input wire logic                       local_master_grant_n,
  input wire cbha_pkg::cbha_dma_status_t dma_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Depth 3 leaves two edges of margin on the five-register pin-to-output path
  AST_HOLD_CAUSE: assert property ($rose(cpu_release_request) |->
    $past(master_cycle_request, 3) || !$past(local_master_request_n, 3))
    else $error("hold raised with no request");
  AST_ACK_AFTER_RELEASE: assert property ($rose(master_cycle_ack) |-> $past(cpu_release_ack, 3))
    else $error("ack before cpu release");
  AST_ACK_CAUSE: assert property ($rose(master_cycle_ack) |->
    $past(master_cycle_request, 3) && cpu_release_request)
    else $error("ack without request or hold");
  AST_NARROW: assert property ($rose(dma_status.narrow_cycle) |-> !$past(narrow_dma_addr_enable_n, 3))
    else $error("narrow cycle without enable");
  AST_WIDE: assert property ($rose(dma_status.wide_cycle) |-> !$past(wide_dma_addr_enable_n, 3))
    else $error("wide cycle without enable");
  AST_LOCAL_GRANT: assert property ($fell(local_master_grant_n) |->
    $past(cpu_release_ack, 3) && !$past(local_master_request_n, 3) && !master_cycle_ack)
    else $error("bad local grant");
  AST_DROP_ORDER: assert property ($fell(master_cycle_ack) || $rose(local_master_grant_n) |=>
    $fell(cpu_release_request))
    else $error("hold not dropped one cycle after ack");
  cover property ($rose(master_cycle_ack));
  cover property ($fell(local_master_grant_n));
  cover property ($rose(dma_status.width_conflict));
endmodule

bind cbha_arbiter cbha_sva u_sva (.clock(clock), .srst(srst), .master_cycle_request(master_cycle_request),
  .cpu_release_ack(cpu_release_ack), .narrow_dma_addr_enable_n(narrow_dma_addr_enable_n),
  .wide_dma_addr_enable_n(wide_dma_addr_enable_n), .local_master_request_n(local_master_request_n),
  .cpu_release_request(cpu_release_request), .master_cycle_ack(master_cycle_ack),
  .local_master_grant_n(local_master_grant_n), .dma_status(dma_status));

`default_nettype wire

// ===== dv/cbha_cpu_model.sv
/*
  Behavioural CPU hold side: follows the release request after a set delay.
  Assumes the bench sets the delay while the request is idle.
*/
`default_nettype none

module cbha_cpu_model (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [3:0] delay,
  input  wire logic       cpu_release_request,
  output var  logic       cpu_release_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_ff;
  // Pins are taken as floated during the wait, so ack only follows it
  always_ff @(posedge clock) begin
    if (srst || cpu_release_request == cpu_release_ack) begin
      wait_ff <= 4'h0;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      cpu_release_ack <= 1'h0;
    end else if (cpu_release_request != cpu_release_ack && wait_ff >= delay) begin
      cpu_release_ack <= cpu_release_request;
    end
  end
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
/*
  Self-checking bench for the CPU bus hold arbiter.
  Assumes the CPU model on the hold pins and the bench as DMA and local master.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       clock;
  logic                       srst;
  logic                       en;
  logic                       mcr;
  logic                       local_master_request_n_n;
  logic                       n8_n;
  logic                       n16_n;
  logic [3:0]                 dly;
  logic                       ack;
  logic                       hold;
  logic                       mack;
  logic                       local_master_grant_n_n;
  cbha_pkg::cbha_dma_status_t st;
  wire logic [3:0]            o;
  int                         err_count = 0;
  int                         comparisons = 0;
  int                         cycles = 0;
  assign o = {ack, local_master_grant_n_n, mack, hold};
  cbha_arbiter dut (.clock(clock), .srst(srst), .clk_en(en), .master_cycle_request(mcr),
    .cpu_release_ack(ack), .narrow_dma_addr_enable_n(n8_n), .wide_dma_addr_enable_n(n16_n),
    .local_master_request_n(local_master_request_n_n), .cpu_release_request(hold), .master_cycle_ack(mack),
    .local_master_grant_n(local_master_grant_n_n), .dma_status(st));
  cbha_cpu_model cpu (.clock(clock), .srst(srst), .delay(dly), .cpu_release_request(hold),
    .cpu_release_ack(ack));
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict;
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Bounded wait on one output bit, always left at a falling edge
  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    while (o[k] !== v && n < 40) begin
      step(1);
      n++;
    end
    if (n == 40) begin
      err_count++;
      $display("wrong value at %0t wait ran out", $time);
    end
  endtask
  task automatic dma_run(input logic [3:0] d);
    dly = d;
    mcr = 1'h1;
    step(4);
    chk(hold, 1'h0);
    step(1);
    chk(hold, 1'h1);
    chk(mack, 1'h0);
    wt(3, 1'h1);
    step(4);
    chk(mack, 1'h0);
    step(1);
    chk(mack, 1'h1);
    n8_n = 1'h0;
    step(5);
    chk(st, 4'h9);
    step(1);
    chk(st, 4'h8);
    n16_n = 1'h0;
    step(6);
    chk(st, 4'hE);
    n8_n = 1'h1;
    n16_n = 1'h1;
    mcr = 1'h0;
    wt(1, 1'h0);
    chk(hold, 1'h1);
    step(1);
    chk(hold, 1'h0);
    wt(3, 1'h0);
    step(8);
  endtask
  task automatic local_run;
    local_master_request_n_n = 1'h0;
    wt(2, 1'h0);
    chk({ack, mack}, 4'h2);
    n8_n = 1'h0;
    step(6);
    chk(st, 4'h0);
    n8_n = 1'h1;
    local_master_request_n_n = 1'h1;
    wt(2, 1'h1);
    step(1);
    chk(hold, 1'h0);
    wt(3, 1'h0);
    step(8);
  endtask
  // Request pulled back while the CPU is slow: no grant may follow
  task automatic withdraw_run;
    dly = 4'hF;
    mcr = 1'h1;
    wt(0, 1'h1);
    mcr = 1'h0;
    repeat (30) begin
      step(1);
      chk(mack, 1'h0);
    end
    wt(0, 1'h0);
    wt(3, 1'h0);
    step(8);
  endtask
  // Enable low freezes the synchronisers: the request is seen only once enable returns
  task automatic freeze_run;
    en = 1'h0;
    mcr = 1'h1;
    step(10);
    chk(hold, 1'h0);
    en = 1'h1;
    step(4);
    chk(hold, 1'h0);
    step(1);
    chk(hold, 1'h1);
    mcr = 1'h0;
    wt(0, 1'h0);
    chk(mack, 1'h0);
    wt(3, 1'h0);
    step(8);
  endtask
  initial begin
    srst = 1'h1;
    en = 1'h1;
    mcr = 1'h0;
    local_master_request_n_n = 1'h1;
    n8_n = 1'h1;
    n16_n = 1'h1;
    dly = 4'h1;
    step(3);
    srst = 1'h0;
    dma_run(4'h1);
    local_run;
    dma_run(4'hA);
    withdraw_run;
    freeze_run;
    give_verdict;
  end
endmodule

`default_nettype wire
